// ===== hw/spimsp_cfg.svh
// register map, field positions and timing constants of the spi port
// Notes on behaviour
// - control readable always; while serial disabled it is forced to reset and port is off.
// - interrupt when complete or fault flag sets, enable set and cpu mask clear.
// - system enable gives the four pins to the port; clearing it stops the clock.
// - mode inputs always act as inputs; mode outputs drive only with direction set.
// - master select-pin direction zero means fault input, one means plain output.
// - open-drain bit makes the four pins open-drain, else push-pull.
// - master select bit sets master mode, clear is slave; resets to zero.
// - master clock rests at the polarity bit level between transfers.
// - rate code 000..111 divides clock by 2,4,16,32,8,16,64,128; master only.
// - extra rate bit adds a divide-by-4 stage and resets to zero.
// - status is always readable and writes to it change nothing.
// - complete flag sets at byte end; cleared by flagged status read then data access.
// - while complete flag is set, data writes are ignored until status read saw it.
// - collision flag cleared by flagged status read then any data access.
// - fault flag cleared by flagged status read then a control write.
// - status bits 5, 3 and 2 always read zero.
// - status bits 1 and 0 show the nmi and irq pin levels.
// - only a master data write starts a byte; both ends flag completion.
// - received bytes go to a read buffer; an unread flag makes new bytes lost.
// - lsb-first bit reverses shift order; register always holds msb at bit 7.
// - slave phase zero shifts only while select is low, select rises between bytes.
// - data write during transfer sets collision, is dropped, transfer goes on.
// - select low in master mode with select-pin direction zero sets fault, clears master bit and directions.
// - slave phase zero busy while selected; phase one from first edge to completion.
`ifndef SPIMSP_CFG_SVH
`define SPIMSP_CFG_SVH

`define SPIMSP_IDX_CTRL  8'h28
`define SPIMSP_IDX_STAT  8'h29
`define SPIMSP_IDX_DATA  8'h2a
`define SPIMSP_IDX_SYSTEM_OPTIONS_TWO  8'h38
`define SPIMSP_IDX_DDR   8'h3c
`define SPIMSP_IDX_CFG   8'h3d

`define SPIMSP_CTRL_RST  8'h04
`define SPIMSP_SYSTEM_OPTIONS_TWO_RST  8'h00
`define SPIMSP_DDR_RST   4'h0
`define SPIMSP_CFG_RST   3'h0

`define SPIMSP_C_IE      7
`define SPIMSP_C_SE      6
`define SPIMSP_C_OD      5
`define SPIMSP_C_MS      4
`define SPIMSP_C_POL     3
`define SPIMSP_C_PHA     2
`define SPIMSP_O_LSB_FIRST_SELECT    3
`define SPIMSP_O_RATE_SELECT_EXTRA    2
`define SPIMSP_F_DIS     0
`define SPIMSP_F_MASK    1
`define SPIMSP_F_SSLVL   2
`define SPIMSP_D_MISO    0
`define SPIMSP_D_MOSI    1
`define SPIMSP_D_SCK     2
`define SPIMSP_D_SS      3
`define SPIMSP_DDR_LO    2

`define SPIMSP_HALF_000  7'h01
`define SPIMSP_HALF_001  7'h02
`define SPIMSP_HALF_010  7'h08
`define SPIMSP_HALF_011  7'h10
`define SPIMSP_HALF_100  7'h04
`define SPIMSP_HALF_101  7'h08
`define SPIMSP_HALF_110  7'h20
`define SPIMSP_HALF_111  7'h40

`define SPIMSP_EDGE_END  4'hf
`define SPIMSP_LAST_P0   4'he
`define SPIMSP_LAST_P1   4'hf

`endif

// ===== hw/spimsp_pkg.sv
// types shared by the spi port
package spimsp_pkg;
	typedef enum logic {
		SPIMSP_IDLE,
		SPIMSP_XFER
	} spimsp_state_e;
endpackage

// ===== hw/spimsp_top.sv
// spi master/slave port with avalon-mm register access
`timescale 1ns/1ps
`include "spimsp_cfg.svh"

module spimsp_top (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe,
	input  wire logic        ss_n_i,
	output logic             ss_n_o,
	output logic             ss_n_oe,
	input  wire logic        nmi_pin_level,
	input  wire logic        irq_pin_level,
	output logic             spi_irq
);

	function automatic logic [6:0] spimsp_half(input logic [2:0] code);
		case (code)
			3'h0: spimsp_half = `SPIMSP_HALF_000;
			3'h1: spimsp_half = `SPIMSP_HALF_001;
			3'h2: spimsp_half = `SPIMSP_HALF_010;
			3'h3: spimsp_half = `SPIMSP_HALF_011;
			3'h4: spimsp_half = `SPIMSP_HALF_100;
			3'h5: spimsp_half = `SPIMSP_HALF_101;
			3'h6: spimsp_half = `SPIMSP_HALF_110;
			default: spimsp_half = `SPIMSP_HALF_111;
		endcase
	endfunction

	function automatic logic [7:0] spimsp_rev(input logic [7:0] b);
		spimsp_rev = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
	endfunction

	logic                      ack_r;
	logic [31:0]               rdata_r;
	logic [7:0]                ctrl_r;
	logic [7:0]                system_options_two_r;
	logic [3:0]                ddr_r;
	logic [2:0]                cfg_r;
	logic                      transfer_complete_flag_r;
	logic                      write_collision_flag_r;
	logic                      mode_fault_flag_r;
	logic                      transfer_complete_flag_arm_r;
	logic                      write_collision_flag_arm_r;
	logic                      mode_fault_flag_arm_r;
	logic [7:0]                shreg_r;
	logic                      rxbit_r;
	logic [7:0]                rdbuf_r;
	spimsp_pkg::spimsp_state_e state_r;
	logic [6:0]                div_r;
	logic [3:0]                ecnt_r;
	logic                      sckph_r;
	logic                      sck_prev_r;

	// bus side: one wait cycle, answer at the second edge of a request
	wire       req      = avs_read | avs_write;
	wire       acc      = req & ack_r;
	wire [7:0] idx      = avs_address[9:2];
	wire       wr_acc   = acc & avs_write & avs_byteenable[0];
	wire       rd_acc   = acc & avs_read;
	wire [7:0] wdat     = avs_writedata[7:0];
	wire       hit_ctrl = (idx == `SPIMSP_IDX_CTRL);
	wire       hit_stat = (idx == `SPIMSP_IDX_STAT);
	wire       hit_data = (idx == `SPIMSP_IDX_DATA);
	wire       hit_system_options_two = (idx == `SPIMSP_IDX_SYSTEM_OPTIONS_TWO);
	wire       hit_ddr  = (idx == `SPIMSP_IDX_DDR);
	wire       hit_cfg  = (idx == `SPIMSP_IDX_CFG);

	assign avs_waitrequest = req & ~ack_r;
	assign avs_readdata    = rdata_r;

	// effective control: forced to reset state while the port is disabled by config
	wire       dis   = cfg_r[`SPIMSP_F_DIS];
	wire [7:0] ctrl  = dis ? `SPIMSP_CTRL_RST : ctrl_r;
	wire       serial_irq_enable  = ctrl[`SPIMSP_C_IE];
	wire       serial_system_enable   = ctrl[`SPIMSP_C_SE];
	wire       od    = ctrl[`SPIMSP_C_OD];
	wire       master_select  = ctrl[`SPIMSP_C_MS];
	wire       clock_polarity  = ctrl[`SPIMSP_C_POL];
	wire       clock_phase  = ctrl[`SPIMSP_C_PHA];
	wire       lsb_first_select  = system_options_two_r[`SPIMSP_O_LSB_FIRST_SELECT];
	wire [2:0] spr   = {system_options_two_r[`SPIMSP_O_RATE_SELECT_EXTRA], ctrl[1:0]};
	wire [6:0] half  = spimsp_half(spr);
	wire       m_mode = serial_system_enable & master_select;
	wire       s_mode = serial_system_enable & ~master_select;

	// master clock generator, halted whenever the port is off
	wire xfer   = (state_r == spimsp_pkg::SPIMSP_XFER);
	wire m_edge = xfer & (div_r == half - 7'h01);
	wire m_end  = m_edge & (ecnt_r == `SPIMSP_EDGE_END);

	// slave edges count only while selected, so select high resets phase zero
	wire s_edge = s_mode & ~ss_n_i & (sck_i ^ sck_prev_r);
	wire edge_e = master_select ? m_edge : s_edge;
	wire lead   = ~ecnt_r[0];
	wire samp   = edge_e & (lead ^ clock_phase);
	wire shft   = edge_e & ~(lead ^ clock_phase) & ~(clock_phase & (ecnt_r == 4'h0));
	wire [3:0] last_idx = clock_phase ? `SPIMSP_LAST_P1 : `SPIMSP_LAST_P0;
	wire done   = samp & (ecnt_r == last_idx);
	wire rx_in  = master_select ? miso_i : mosi_i;
	wire [7:0] done_byte = {shreg_r[6:0], rx_in};
	wire s_rst  = ~master_select & ~clock_phase & ss_n_i;

	// transfer in progress, as seen for collisions
	wire busy = master_select ? xfer : (clock_phase ? (ecnt_r != 4'h0) : ~ss_n_i);

	// data register access
	wire dacc    = acc & hit_data;
	wire dwr     = wr_acc & hit_data;
	wire data_ok = ~transfer_complete_flag_r | transfer_complete_flag_arm_r;
	wire coll    = dwr & data_ok & busy;
	wire load    = dwr & data_ok & ~busy;
	wire start   = load & m_mode;

	// mode fault: select pulled low while mastering with fault detect on
	wire mf_ev = m_mode & ~ddr_r[`SPIMSP_D_SS] & ~ss_n_i;

	// flag set and clear; a set in the same cycle as a clear wins
	wire rd_stat  = rd_acc & hit_stat;
	wire transfer_complete_flag_clr = transfer_complete_flag_arm_r & dacc;
	wire write_collision_flag_clr = write_collision_flag_arm_r & dacc;
	wire mode_fault_flag_clr = mode_fault_flag_arm_r & wr_acc & hit_ctrl;
	wire transfer_complete_flag_nxt = done | (transfer_complete_flag_r & ~transfer_complete_flag_clr);
	wire write_collision_flag_nxt = coll | (write_collision_flag_r & ~write_collision_flag_clr);
	wire mode_fault_flag_nxt = mf_ev | (mode_fault_flag_r & ~mode_fault_flag_clr);
	wire transfer_complete_flag_arm_nxt = rd_stat ? rdata_r[7] : (transfer_complete_flag_arm_r & ~transfer_complete_flag_clr);
	wire write_collision_flag_arm_nxt = rd_stat ? rdata_r[6] : (write_collision_flag_arm_r & ~write_collision_flag_clr);
	wire mode_fault_flag_arm_nxt = rd_stat ? rdata_r[4] : (mode_fault_flag_arm_r & ~mode_fault_flag_clr);

	// register next values
	wire [7:0] ctrl_wr  = (wr_acc & hit_ctrl) ? wdat : ctrl_r;
	wire [7:0] ctrl_nxt = dis ? `SPIMSP_CTRL_RST
	                          : (ctrl_wr & ~({7'h00, mf_ev} << `SPIMSP_C_MS));
	wire [3:0] ddr_nxt  = mf_ev ? `SPIMSP_DDR_RST
	                    : ((wr_acc & hit_ddr) ? wdat[5:2] : ddr_r);
	wire [7:0] system_options_two_nxt = (wr_acc & hit_system_options_two) ? wdat : system_options_two_r;
	wire [2:0] cfg_nxt  = (wr_acc & hit_cfg) ? wdat[2:0] : cfg_r;

	// status: unused bits zero, low bits follow the interrupt pins
	wire [7:0] stat = {transfer_complete_flag_r, write_collision_flag_r, 1'b0, mode_fault_flag_r, 1'b0, 1'b0,
	                   nmi_pin_level, irq_pin_level};

	wire [7:0] rsel = hit_ctrl ? ctrl
	                : hit_stat ? stat
	                : hit_data ? rdbuf_r
	                : hit_system_options_two ? system_options_two_r
	                : hit_ddr  ? {2'h0, ddr_r, 2'h0}
	                : hit_cfg  ? {5'h00, cfg_r}
	                : 8'h00;
	wire [31:0] rdata_nxt = (avs_read & ~ack_r) ? {24'h0000_00, rsel} : rdata_r;

	// shifter: always msb-first inside, reversed at the edges for lsb-first
	wire [7:0] load_byte = lsb_first_select ? spimsp_rev(wdat) : wdat;
	wire [7:0] rx_byte   = lsb_first_select ? spimsp_rev(done_byte) : done_byte;
	wire [7:0] shreg_nxt = load ? load_byte
	                     : shft ? {shreg_r[6:0], rxbit_r}
	                     : shreg_r;
	// a byte arriving while the flag is still up is dropped: overrun
	wire [7:0] rdbuf_nxt = (done & ~transfer_complete_flag_r) ? rx_byte : rdbuf_r;
	wire       rxbit_nxt = samp ? rx_in : rxbit_r;

	// master sequencer
	wire stop = m_end | mf_ev | ~m_mode;
	spimsp_pkg::spimsp_state_e state_nxt;
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			spimsp_pkg::SPIMSP_IDLE: if (start) state_nxt = spimsp_pkg::SPIMSP_XFER;
			spimsp_pkg::SPIMSP_XFER: if (stop) state_nxt = spimsp_pkg::SPIMSP_IDLE;
		endcase
	end

	wire [6:0] div_nxt  = (~xfer | m_edge) ? 7'h00 : div_r + 7'h01;
	wire [3:0] ecnt_nxt = (~serial_system_enable | start | s_rst) ? 4'h0
	                    : edge_e ? ecnt_r + 4'h1 : ecnt_r;
	wire       sckph_nxt = (state_nxt == spimsp_pkg::SPIMSP_XFER) & (sckph_r ^ m_edge);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
			ctrl_r  <= `SPIMSP_CTRL_RST;
			system_options_two_r  <= `SPIMSP_SYSTEM_OPTIONS_TWO_RST;
			ddr_r   <= `SPIMSP_DDR_RST;
			cfg_r   <= `SPIMSP_CFG_RST;
		end else begin
			ack_r   <= req & ~ack_r;
			rdata_r <= rdata_nxt;
			ctrl_r  <= ctrl_nxt;
			system_options_two_r  <= system_options_two_nxt;
			ddr_r   <= ddr_nxt;
			cfg_r   <= cfg_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			transfer_complete_flag_r     <= 1'b0;
			write_collision_flag_r     <= 1'b0;
			mode_fault_flag_r     <= 1'b0;
			transfer_complete_flag_arm_r <= 1'b0;
			write_collision_flag_arm_r <= 1'b0;
			mode_fault_flag_arm_r <= 1'b0;
		end else begin
			transfer_complete_flag_r     <= transfer_complete_flag_nxt;
			write_collision_flag_r     <= write_collision_flag_nxt;
			mode_fault_flag_r     <= mode_fault_flag_nxt;
			transfer_complete_flag_arm_r <= transfer_complete_flag_arm_nxt;
			write_collision_flag_arm_r <= write_collision_flag_arm_nxt;
			mode_fault_flag_arm_r <= mode_fault_flag_arm_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shreg_r    <= 8'h00;
			rxbit_r    <= 1'b0;
			rdbuf_r    <= 8'h00;
			state_r    <= spimsp_pkg::SPIMSP_IDLE;
			div_r      <= 7'h00;
			ecnt_r     <= 4'h0;
			sckph_r    <= 1'b0;
			sck_prev_r <= 1'b0;
		end else begin
			shreg_r    <= shreg_nxt;
			rxbit_r    <= rxbit_nxt;
			rdbuf_r    <= rdbuf_nxt;
			state_r    <= state_nxt;
			div_r      <= div_nxt;
			ecnt_r     <= ecnt_nxt;
			sckph_r    <= sckph_nxt;
			sck_prev_r <= sck_i;
		end
	end

	// pins: inputs of the mode never drive; outputs need their direction bit
	wire drv_sck  = m_mode & ddr_r[`SPIMSP_D_SCK];
	wire drv_mosi = m_mode & ddr_r[`SPIMSP_D_MOSI];
	wire drv_miso = s_mode & ddr_r[`SPIMSP_D_MISO] & ~ss_n_i;
	wire drv_ss   = m_mode & ddr_r[`SPIMSP_D_SS];

	assign sck_o   = clock_polarity ^ sckph_r;
	assign mosi_o  = shreg_r[7];
	assign miso_o  = shreg_r[7];
	assign ss_n_o  = cfg_r[`SPIMSP_F_SSLVL];

	// open-drain pins only pull low, never drive a high
	assign sck_oe  = drv_sck  & (~od | ~sck_o);
	assign mosi_oe = drv_mosi & (~od | ~mosi_o);
	assign miso_oe = drv_miso & (~od | ~miso_o);
	assign ss_n_oe = drv_ss   & (~od | ~ss_n_o);

	assign spi_irq = serial_irq_enable & (transfer_complete_flag_r | mode_fault_flag_r) & ~cfg_r[`SPIMSP_F_MASK];

endmodule

// ===== dv/spimsp_monitor.sv
// port-level checker for the spi master/slave port
`timescale 1ns/1ps
`include "spimsp_cfg.svh"
module spimsp_monitor (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [9:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        sck_oe,
	input wire logic        mosi_oe,
	input wire logic        miso_oe,
	input wire logic        ss_n_i,
	input wire logic        ss_n_oe,
	input wire logic        nmi_pin_level,
	input wire logic        irq_pin_level,
	input wire logic        spi_irq
);
	wire req   = avs_read | avs_write;
	wire rd_ok = avs_read & ~avs_waitrequest;
	wire st    = avs_address[9:2] == `SPIMSP_IDX_STAT;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wait_first_a: assert property (req && !$past(req && avs_waitrequest) |-> avs_waitrequest)
		else $error("no wait cycle at start of request");
	wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait held longer than one cycle");
	hi_zero_a: assert property (rd_ok |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	stat_zero_a: assert property (rd_ok && st |-> avs_readdata[5] == 1'b0 && avs_readdata[3:2] == 2'h0)
		else $error("unused status bits not zero");
	stat_pins_a: assert property (rd_ok && st && $stable(nmi_pin_level) && $stable(irq_pin_level)
		|-> avs_readdata[1:0] == {nmi_pin_level, irq_pin_level})
		else $error("status pin bits differ from pins");
	rst_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !(sck_oe | mosi_oe | miso_oe | ss_n_oe | spi_irq))
		else $error("pin driven or irq after reset");
	pin_dir_a: assert property (!(miso_oe && (sck_oe || mosi_oe)))
		else $error("input pin of mode is driven");
	fault_off_a: assert property (sck_oe && !ss_n_oe && !ss_n_i |-> ##[1:4] !(sck_oe || mosi_oe))
		else $error("drivers not off after mode fault");
	cover property (spi_irq);
	cover property (sck_oe && !ss_n_i && !ss_n_oe);
	cover property (rd_ok && st);
endmodule

// ===== dv/spimsp_slave_model.sv
// behavioural spi slave on the far side, clock mode 0, msb first
`timescale 1ns/1ps
module spimsp_slave_model (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       ss_n,
	input  wire logic [7:0] tx,
	output logic            miso,
	output logic      [7:0] rx
);
	logic [7:0] sh = 8'h00;
	logic       last = 1'b0;
	// released line shows the inverse of its last bit so stale data cannot pass
	assign miso = ss_n ? ~last : sh[7];
	always @(negedge ss_n) sh = tx;
	always @(posedge ss_n) last = sh[7];
	always @(posedge sck) if (!ss_n) rx = {rx[6:0], mosi};
	always @(negedge sck) if (!ss_n) sh = {sh[6:0], 1'b0};
endmodule

// ===== dv/tb_spimsp_top.sv
// self-checking bench for the spi master/slave port
`timescale 1ns/1ps
`include "spimsp_cfg.svh"
module tb_spimsp_top;
	localparam logic [7:0] CT = `SPIMSP_IDX_CTRL, ST = `SPIMSP_IDX_STAT, DT = `SPIMSP_IDX_DATA;
	localparam logic [7:0] OP = `SPIMSP_IDX_SYSTEM_OPTIONS_TWO, DR = `SPIMSP_IDX_DDR, CF = `SPIMSP_IDX_CFG;
	logic        clk, rst_n, avs_read, avs_write, ss_in, s_ss, nmi_pin_level, irq_pin_level;
	logic [9:0]  avs_address;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [7:0]  s_tx, v, d;
	logic [7:0]  hw [8] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h04, 8'h08, 8'h20, 8'h40};
	wire  [31:0] avs_readdata;
	wire  [7:0]  s_rx;
	wire         avs_waitrequest, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	wire         ss_n_o, ss_n_oe, spi_irq, s_miso;
	wire         sck_i  = sck_oe ? sck_o : 1'b0;
	wire         mosi_i = mosi_oe ? mosi_o : 1'b0;
	wire         miso_i = miso_oe ? miso_o : s_miso;
	wire         ss_n_i = ss_n_oe ? ss_n_o : ss_in;
	int          fails, n_checks, n_sck, h, n, k;
	spimsp_top spimsp_top_i (.*);
	spimsp_slave_model spimsp_slave_model_i (.sck(sck_i), .mosi(mosi_i), .ss_n(s_ss),
		.tx(s_tx), .miso(s_miso), .rx(s_rx));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge sck_o) n_sck++;
	function automatic logic [7:0] rev(input logic [7:0] x);
		for (int i = 0; i < 8; i++) rev[i] = x[7-i];
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chb(input string nm, input logic e, input logic g);
		chk(nm, {7'h0, e}, {7'h0, g});
	endtask
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] dd);
		int j;
		logic wt;
		@(posedge clk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, dd};
		avs_read <= ~w;
		avs_write <= w;
		j = 0;
		// look at the answer mid-cycle, so the edge that follows is the one it is taken on
		do begin
			@(negedge clk);
			wt = avs_waitrequest;
			v = avs_readdata[7:0];
			@(posedge clk);
			j++;
		end while (wt !== 1'b0 && j < 20);
		if (j >= 20) fails++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		#1;
	endtask
	task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk(nm, e, v);
	endtask
	task automatic start(input logic [7:0] dd);
		s_ss <= 1'b1;
		@(posedge clk);
		s_ss <= 1'b0;
		bus(1'b1, DT, dd);
	endtask
	task automatic poll;
		v = 8'h00;
		for (int j = 0; j < 400 && !v[7]; j++) bus(1'b0, ST, 8'h00);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		$display("ERROR watchdog expected done seen timeout");
		close_out;
	end
	initial begin
		{rst_n, avs_read, avs_write, ss_in, s_ss, nmi_pin_level, irq_pin_level} = 7'h0e;
		{avs_address, avs_writedata, s_tx, v} = '0;
		avs_byteenable = 4'h1;
		{fails, n_checks, n_sck} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rdc("ctrl_rst", CT, 8'h04);
		rdc("opt_rst", OP, 8'h00);
		bus(1'b1, ST, 8'hff);
		rdc("stat_wr", ST, 8'h02);
		irq_pin_level <= 1'b1;
		rdc("stat_pins", ST, 8'h03);
		irq_pin_level <= 1'b0;
		rdc("unmapped", 8'h30, 8'h00);
		$display("test registers done");
		bus(1'b1, DR, 8'h18);
		for (int c = 0; c < 8; c++) begin
			bus(1'b1, OP, {4'h0, c[0], c[2], 2'h0});
			bus(1'b1, CT, {6'h14, c[1:0]});
			d = 8'h1d ^ c[7:0];
			s_tx = 8'hb2 ^ c[7:0];
			n = n_sck;
			fork
				begin
					start(d);
					poll;
				end
				begin
					@(posedge sck_o);
					h = 0;
					do begin
						@(posedge clk);
						#1;
						h++;
					end while (sck_o && h < 200);
				end
			join
			chk("half", hw[c], h[7:0]);
			chk("edges", 8'h08, 8'(n_sck - n));
			chk("sent", c[0] ? rev(d) : d, s_rx);
			rdc("recv", DT, c[0] ? rev(s_tx) : s_tx);
			rdc("flag_clr", ST, 8'h02);
			for (k = 0; k < 200 && sck_o; k++) @(posedge clk);
			chb("idle_low", 1'b0, sck_o);
		end
		$display("test rates done");
		bus(1'b1, OP, 8'h00);
		bus(1'b1, CT, 8'hd0);
		start(8'h96);
		bus(1'b1, DT, 8'h69);
		poll;
		chk("write_collision_flag", 8'hc2, v);
		chk("kept", 8'h96, s_rx);
		chb("irq", 1'b1, spi_irq);
		bus(1'b0, DT, 8'h00);
		rdc("write_collision_flag_clr", ST, 8'h02);
		s_tx = 8'h5a;
		start(8'h11);
		for (k = 0; k < 300 && spi_irq !== 1'b1; k++) @(posedge clk);
		n = n_sck;
		bus(1'b1, DT, 8'h22);
		repeat (8) @(posedge clk);
		chb("no_start", 1'b1, n_sck == n);
		bus(1'b1, CF, 8'h02);
		chb("masked", 1'b0, spi_irq);
		bus(1'b1, CF, 8'h00);
		chb("unmasked", 1'b1, spi_irq);
		rdc("st_armed", ST, 8'h82);
		rdc("recv2", DT, s_tx);
		chb("irq_off", 1'b0, spi_irq);
		$display("test flags done");
		ss_in <= 1'b0;
		for (k = 0; k < 300 && spi_irq !== 1'b1; k++) @(posedge clk);
		chb("fault_irq", 1'b1, spi_irq);
		ss_in <= 1'b1;
		rdc("mode_fault_flag", ST, 8'h12);
		rdc("master_select_clr", CT, 8'hc0);
		rdc("ddr_clr", DR, 8'h00);
		bus(1'b1, CT, 8'h50);
		rdc("mode_fault_flag_clr", ST, 8'h02);
		$display("test fault done");
		bus(1'b1, DR, 8'h18);
		bus(1'b1, CT, 8'h58);
		chb("idle_high", 1'b1, sck_o);
		bus(1'b1, CT, 8'h78);
		chb("od_high", 1'b0, sck_oe);
		bus(1'b1, CT, 8'h70);
		chb("od_low", 1'b1, sck_oe);
		bus(1'b1, CF, 8'h01);
		bus(1'b1, CT, 8'h50);
		rdc("ctrl_dis", CT, 8'h04);
		bus(1'b1, CF, 8'h00);
		bus(1'b1, CT, 8'h50);
		rdc("ctrl_en", CT, 8'h50);
		$display("test pins done");
		close_out;
	end
endmodule
bind spimsp_top spimsp_monitor spimsp_monitor_i (.*);
